// ---- core/gpio_fg_map.vh ----
`ifndef GPIO_FG_MAP_VH
`define GPIO_FG_MAP_VH
// ----------------------------------------
// register word indices; byte address is four times the index
// ----------------------------------------
`define F_DIRECTION_REG_OFS 4'h0
`define F_PIN_REG_OFS 4'h1
`define F_LATCH_REG_OFS 4'h2
`define G_DIRECTION_REG_OFS 4'h3
`define G_PIN_REG_OFS 4'h4
`define G_LATCH_REG_OFS 4'h5
`define F_ANALOG_SEL_OFS 4'h6
`define F_ALT_SEL_OFS 4'h7
`define G_ALT_SEL_OFS 4'h8
// ----------------------------------------
// reset values
// ----------------------------------------
`define F_DIRECTION_RST 8'hff
`define F_LATCH_RST 8'h00
`define G_DIRECTION_RST 5'h1f
`define G_LATCH_RST 5'h00
`define F_ANALOG_SEL_RST 7'h7f
`define F_ALT_SEL_RST 4'h0
`define G_ALT_SEL_RST 5'h00
`define G_SYNC_RST 5'h04
// ----------------------------------------
// alternate-function bit positions
// ----------------------------------------
`define F_ALT_CMP_TWO_OUT 0
`define F_ALT_CMP_ONE_OUT 1
`define F_ALT_CMP_REF_OUT 2
`define F_ALT_SS 3
`define G_ALT_CAPCMP_CH3 0
`define G_ALT_USART 1
`define G_ALT_CAPCMP_CH4 3
`define G_ALT_CAPCMP_CH5 4
`endif

// ---- core/dual_gpio_port_f_g.v ----
`timescale 1ns/100ps
`include "gpio_fg_map.vh"
module dual_gpio_port_f_g
(
    // system
    input wire clk,
    input wire resetn,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // port f pins
    input wire [7:0] f_pin_in,
    output reg [7:0] f_pin_out,
    output reg [7:0] f_pin_oe,
    // port g pins
    input wire [4:0] g_pin_in,
    output reg [4:0] g_pin_out,
    output reg [4:0] g_pin_oe,
    // comparator, reference, analog channel and slave-select peripherals
    input wire comparator_one_out,
    input wire comparator_two_out,
    input wire comparator_reference_out,
    output reg [6:0] analog_channel_in,
    output reg ssp_slave_select_n,
    // capture/compare channels 3..5
    input wire [2:0] ccp_out,
    input wire [2:0] ccp_out_en,
    output reg [2:0] ccp_capture_in,
    // usart two
    input wire usart_two_tx_clk,
    input wire usart_two_tx_clk_oe,
    input wire usart_two_rx_data_out,
    input wire usart_two_rx_data_oe,
    output reg usart_two_rx_data,
    output reg usart_two_clk_in
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] f_direction_reg;
reg [7:0] f_latch_reg;
reg [4:0] g_direction_reg;
reg [4:0] g_latch_reg;
reg [6:0] f_analog_sel;
reg [3:0] f_alt_sel;
reg [4:0] g_alt_sel;
reg [7:0] f_sync1;
reg [7:0] f_sync2;
reg [4:0] g_sync1;
reg [4:0] g_sync2;

// ----------------------------------------
// bus decode
// ----------------------------------------
// one access per ack: the cycle that acks never starts another
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
wire [3:0] reg_idx = wb_adr_i[5:2];

function hit;
    input [3:0] idx;
    input [3:0] ofs;
    begin
        hit = (idx == ofs);
    end
endfunction

// ----------------------------------------
// register write strobes
// ----------------------------------------
wire f_dir_we = wb_wr & hit(reg_idx, `F_DIRECTION_REG_OFS);
// pin and latch addresses both land in the latch
wire f_latch_we = wb_wr & (hit(reg_idx, `F_PIN_REG_OFS) | hit(reg_idx, `F_LATCH_REG_OFS));
wire g_dir_we = wb_wr & hit(reg_idx, `G_DIRECTION_REG_OFS);
wire g_latch_we = wb_wr & (hit(reg_idx, `G_PIN_REG_OFS) | hit(reg_idx, `G_LATCH_REG_OFS));
wire f_analog_we = wb_wr & hit(reg_idx, `F_ANALOG_SEL_OFS);
wire f_alt_we = wb_wr & hit(reg_idx, `F_ALT_SEL_OFS);
wire g_alt_we = wb_wr & hit(reg_idx, `G_ALT_SEL_OFS);

// ----------------------------------------
// port f registers
// ----------------------------------------
// overrides never reach the direction registers
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        f_direction_reg <= `F_DIRECTION_RST;
        f_latch_reg <= `F_LATCH_RST;
    end
    else
    begin
        if (f_dir_we)
            f_direction_reg <= wb_dat_i[7:0];
        if (f_latch_we)
            f_latch_reg <= wb_dat_i[7:0];
    end
end

// ----------------------------------------
// port g registers
// ----------------------------------------
// only five bits are stored, so the upper three cannot be written
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        g_direction_reg <= `G_DIRECTION_RST;
        g_latch_reg <= `G_LATCH_RST;
    end
    else
    begin
        if (g_dir_we)
            g_direction_reg <= wb_dat_i[4:0];
        if (g_latch_we)
            g_latch_reg <= wb_dat_i[4:0];
    end
end

// ----------------------------------------
// alternate-function selects
// ----------------------------------------
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        f_analog_sel <= `F_ANALOG_SEL_RST;
        f_alt_sel <= `F_ALT_SEL_RST;
        g_alt_sel <= `G_ALT_SEL_RST;
    end
    else
    begin
        if (f_analog_we)
            f_analog_sel <= wb_dat_i[6:0];
        if (f_alt_we)
            f_alt_sel <= wb_dat_i[3:0];
        if (g_alt_we)
            g_alt_sel <= wb_dat_i[4:0];
    end
end

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// pins are asynchronous; only the second stage is read by any logic
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        f_sync1 <= 8'h00;
        f_sync2 <= 8'h00;
    end
    else
    begin
        f_sync1 <= f_pin_in;
        f_sync2 <= f_sync1;
    end
end

// receive data idles high; a low reset value would fake a start bit
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        g_sync1 <= `G_SYNC_RST;
        g_sync2 <= `G_SYNC_RST;
    end
    else
    begin
        g_sync1 <= g_pin_in;
        g_sync2 <= g_sync1;
    end
end

// analog-selected pins read zero, digital buffer is disabled there
wire [7:0] f_read = f_sync2 & ~{1'b0, f_analog_sel};

// ----------------------------------------
// bus read and ack
// ----------------------------------------
reg [31:0] next_rdata;
always @*
begin
    next_rdata = 32'h0000_0000;
    case (reg_idx)
        `F_DIRECTION_REG_OFS: next_rdata[7:0] = f_direction_reg;
        `F_PIN_REG_OFS: next_rdata[7:0] = f_read;
        `F_LATCH_REG_OFS: next_rdata[7:0] = f_latch_reg;
        `G_DIRECTION_REG_OFS: next_rdata[4:0] = g_direction_reg;
        `G_PIN_REG_OFS: next_rdata[4:0] = g_sync2;
        `G_LATCH_REG_OFS: next_rdata[4:0] = g_latch_reg;
        `F_ANALOG_SEL_OFS: next_rdata[6:0] = f_analog_sel;
        `F_ALT_SEL_OFS: next_rdata[3:0] = f_alt_sel;
        `G_ALT_SEL_OFS: next_rdata[4:0] = g_alt_sel;
        default: next_rdata = 32'h0000_0000;
    endcase
end

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
        // unmapped addresses still ack, reading zero
        wb_ack_o <= wb_req;
        wb_dat_o <= wb_req ? next_rdata : 32'h0000_0000;
    end
end

// ----------------------------------------
// pin muxing with peripheral overrides
// ----------------------------------------
reg [7:0] next_f_out;
reg [7:0] next_f_oe;
reg [4:0] next_g_out;
reg [4:0] next_g_oe;
always @*
begin
    next_f_out = f_latch_reg;
    next_f_oe = ~f_direction_reg;
    next_f_oe[6:0] = next_f_oe[6:0] & ~f_analog_sel;
    if (f_alt_sel[`F_ALT_CMP_TWO_OUT])
    begin
        next_f_out[1] = comparator_two_out;
        next_f_oe[1] = 1'b1;
    end
    if (f_alt_sel[`F_ALT_CMP_ONE_OUT])
    begin
        next_f_out[2] = comparator_one_out;
        next_f_oe[2] = 1'b1;
    end
    if (f_alt_sel[`F_ALT_CMP_REF_OUT])
    begin
        next_f_out[5] = comparator_reference_out;
        next_f_oe[5] = 1'b1;
    end
    // slave select is an input only, so it forces the driver off
    if (f_alt_sel[`F_ALT_SS])
        next_f_oe[7] = 1'b0;
end

// ----------------------------------------
// port g pin muxing
// ----------------------------------------
// here the peripherals choose direction through their own enables
always @*
begin
    next_g_out = g_latch_reg;
    next_g_oe = ~g_direction_reg;
    if (g_alt_sel[`G_ALT_CAPCMP_CH3])
    begin
        next_g_out[0] = ccp_out[0];
        next_g_oe[0] = ccp_out_en[0];
    end
    if (g_alt_sel[`G_ALT_USART])
    begin
        next_g_out[1] = usart_two_tx_clk;
        next_g_oe[1] = usart_two_tx_clk_oe;
        next_g_out[2] = usart_two_rx_data_out;
        next_g_oe[2] = usart_two_rx_data_oe;
    end
    if (g_alt_sel[`G_ALT_CAPCMP_CH4])
    begin
        next_g_out[3] = ccp_out[1];
        next_g_oe[3] = ccp_out_en[1];
    end
    if (g_alt_sel[`G_ALT_CAPCMP_CH5])
    begin
        next_g_out[4] = ccp_out[2];
        next_g_oe[4] = ccp_out_en[2];
    end
end

// ----------------------------------------
// pin drivers
// ----------------------------------------
// registered, so a pin follows a register write one edge later
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        f_pin_out <= 8'h00;
        f_pin_oe <= 8'h00;
        g_pin_out <= 5'h00;
        g_pin_oe <= 5'h00;
    end
    else
    begin
        f_pin_out <= next_f_out;
        f_pin_oe <= next_f_oe;
        g_pin_out <= next_g_out;
        g_pin_oe <= next_g_oe;
    end
end

// ----------------------------------------
// peripheral inputs
// ----------------------------------------
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        analog_channel_in <= 7'h00;
        ssp_slave_select_n <= 1'b1; // deselected while idle
        ccp_capture_in <= 3'h0;
        usart_two_rx_data <= 1'b1; // idle line level
        usart_two_clk_in <= 1'b0;
    end
    else
    begin
        analog_channel_in <= f_sync2[6:0] & f_analog_sel;
        ssp_slave_select_n <= f_alt_sel[`F_ALT_SS] ? f_sync2[7] : 1'b1;
        ccp_capture_in <= {g_sync2[4], g_sync2[3], g_sync2[0]};
        usart_two_rx_data <= g_sync2[2];
        usart_two_clk_in <= g_sync2[1];
    end
end

endmodule // dual_gpio_port_f_g

// ---- verif/gpio_fg_assertions.sv ----
`timescale 1ns/100ps
module gpio_fg_checker
(
    // bus
    input wire clk,
    input wire resetn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // pins
    input wire [4:0] g_pin_in,
    input wire [7:0] f_pin_oe,
    input wire [4:0] g_pin_oe,
    input wire [2:0] ccp_capture_in,
    input wire usart_two_rx_data,
    input wire usart_two_clk_in
);
    reg [3:0] up;
    // synchronisers hold stale values for a few edges after reset
    always @(posedge clk or negedge resetn)
        if (!resetn)
            up <= 4'h0;
        else if (up != 4'hf)
            up <= up + 4'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence read_ack;
        wb_ack_o && !wb_we_i;
    endsequence
    sequence g_steady;
        (up > 4'h6 && $stable(g_pin_in)) [*4];
    endsequence
    a_ack_after_take: assert property (taken |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_read_byte_wide: assert property (read_ack |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_g_upper_zero: assert property (read_ack ##0 (wb_adr_i[5:2] >= 4'h3 &&
        wb_adr_i[5:2] <= 4'h5) |-> wb_dat_o[7:5] == 3'h0) else $error("port g upper bits set");
    a_reset_inputs: assert property ($rose(resetn) |-> f_pin_oe == 8'h00 &&
        g_pin_oe == 5'h00) else $error("pin driven after reset");
    a_capture_follows: assert property (g_steady |->
        ccp_capture_in == {g_pin_in[4], g_pin_in[3], g_pin_in[0]}) else $error("capture path");
    a_usart_follows: assert property (g_steady |-> usart_two_rx_data == g_pin_in[2] &&
        usart_two_clk_in == g_pin_in[1]) else $error("usart input path");
endmodule // gpio_fg_checker
bind dual_gpio_port_f_g gpio_fg_checker u_gpio_fg_checker (.clk(clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .g_pin_in(g_pin_in), .f_pin_oe(f_pin_oe),
    .g_pin_oe(g_pin_oe), .ccp_capture_in(ccp_capture_in),
    .usart_two_rx_data(usart_two_rx_data), .usart_two_clk_in(usart_two_clk_in));

// ---- verif/dual_gpio_port_f_g_bench.sv ----
`timescale 1ns/100ps
`include "gpio_fg_map.vh"
module dual_gpio_port_f_g_bench;
    logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [7:0] dw = 8'h00, f_in = 8'h00, q;
    logic [4:0] g_in = 5'h00;
    logic c1 = 1'b0, c2 = 1'b0, cref = 1'b0, tx = 1'b0, tx_oe = 1'b0, rx_oe = 1'b0, rxd = 1'b0;
    logic [2:0] ccp_o = 3'h0, ccp_en = 3'h0;
    wire [31:0] dr;
    wire ack, ss_n;
    wire [7:0] f_out, f_oe;
    wire [4:0] g_out, g_oe;
    wire [6:0] an;
    integer mismatches = 0, checks_done = 0, cycles = 0;
    dual_gpio_port_f_g u_dual_gpio_port_f_g (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i({24'h00_0000, dw}), .wb_dat_o(dr), .wb_ack_o(ack), .f_pin_in(f_in),
        .f_pin_out(f_out), .f_pin_oe(f_oe), .g_pin_in(g_in), .g_pin_out(g_out), .g_pin_oe(g_oe),
        .comparator_one_out(c1), .comparator_two_out(c2), .comparator_reference_out(cref),
        .analog_channel_in(an), .ssp_slave_select_n(ss_n), .ccp_out(ccp_o), .ccp_out_en(ccp_en),
        .ccp_capture_in(), .usart_two_tx_clk(tx), .usart_two_tx_clk_oe(tx_oe),
        .usart_two_rx_data_out(rxd), .usart_two_rx_data_oe(rx_oe), .usart_two_rx_data(),
        .usart_two_clk_in());
    initial forever #5 clk = ~clk;
    always @(posedge clk)
        if (++cycles == 3000)
        begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; ack is sampled at the edge that ends it
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dw <= d;
        while (ack !== 1'b1)
            @(posedge clk);
        q = dr[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(q, exp);
    endtask
    task automatic t_reset;
        rd(`F_DIRECTION_REG_OFS, 8'hff);
        rd(`G_DIRECTION_REG_OFS, 8'h1f);
        check(f_oe, 8'h00);
        check({3'h0, g_oe}, 8'h00);
        f_in <= 8'hff;
        repeat (4) @(posedge clk);
        rd(`F_PIN_REG_OFS, 8'h80);
        check({1'b0, an}, 8'h7f);
        check({7'h00, ss_n}, 8'h01);
        $display("test reset done");
    endtask
    task automatic t_port_g;
        bus(1'b1, `G_PIN_REG_OFS, 8'h0a);
        bus(1'b1, `G_DIRECTION_REG_OFS, 8'h04);
        g_in <= 5'h11;
        repeat (4) @(posedge clk);
        check({3'h0, g_oe}, 8'h1b);
        check({3'h0, g_out & g_oe}, 8'h0a);
        rd(`G_LATCH_REG_OFS, 8'h0a);
        rd(`G_PIN_REG_OFS, 8'h11);
        bus(1'b1, `G_LATCH_REG_OFS, 8'hff);
        rd(`G_LATCH_REG_OFS, 8'h1f);
        rd(4'h9, 8'h00);
        $display("test port_g done");
    endtask
    // peripherals take pins without touching the direction registers
    task automatic t_override;
        bus(1'b1, `G_DIRECTION_REG_OFS, 8'h1f);
        bus(1'b1, `G_ALT_SEL_OFS, 8'h1b);
        bus(1'b1, `F_ANALOG_SEL_OFS, 8'h00);
        bus(1'b1, `F_DIRECTION_REG_OFS, 8'h00);
        bus(1'b1, `F_ALT_SEL_OFS, 8'h0f);
        bus(1'b1, `F_LATCH_REG_OFS, 8'h04);
        bus(1'b1, `G_LATCH_REG_OFS, 8'h00);
        ccp_en <= 3'h5;
        ccp_o <= 3'h5;
        tx_oe <= 1'b1;
        rx_oe <= 1'b1;
        rxd <= 1'b1;
        tx <= 1'b1;
        c2 <= 1'b1;
        cref <= 1'b1;
        f_in <= 8'h00;
        repeat (4) @(posedge clk);
        check({3'h0, g_oe}, 8'h17);
        check({3'h0, g_out & g_oe}, 8'h17);
        rd(`G_DIRECTION_REG_OFS, 8'h1f);
        check(f_oe, 8'h7f);
        check(f_out & f_oe, 8'h22);
        check({7'h00, ss_n}, 8'h00);
        $display("test override done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_port_g;
        t_override;
        report_and_stop;
    end
endmodule // dual_gpio_port_f_g_bench
